// ==== tb/lfcr_checker.sv ====
// Checker that watches the ports of the link format register.
`timescale 1ns/1ps
`default_nettype none
module lfcr_checker
  import lfcr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic local_channel_enable_pin,
  input wire logic double_strap_pin,
  input wire logic width_strap_pin,
  input wire logic edge_strap_pin,
  input wire logic sync_strap_pin,
  input wire logic check_strap_pin,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic config_ready,
  input wire logic double_input_select,
  input wire logic rate_select,
  input wire logic word_width_select,
  input wire logic output_edge_select,
  input wire logic sync_tracking_enable,
  input wire logic sync_encoding_enable,
  input wire logic [1:0] error_check_mode,
  input wire logic link_valid,
  input wire logic [23:0] link_data,
  input wire logic [5:0] link_check,
  input wire logic out_valid,
  input wire logic [23:0] out_data,
  input wire logic err_detected
);
  logic [7:0] cfg;
  logic gate;
  // Fields gathered in register bit order; straps count only with the local enable low.
  assign cfg = {double_input_select, rate_select, word_width_select, output_edge_select,
    sync_tracking_enable, sync_encoding_enable, error_check_mode};
  assign gate = !local_channel_enable_pin;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  a_strap_double: assert property (
    $rose(config_ready) |-> double_input_select == (gate && double_strap_pin))
    else $error("double default wrong");
  a_strap_width: assert property (
    $rose(config_ready) |-> word_width_select == (gate && width_strap_pin))
    else $error("width default wrong");
  a_strap_edge: assert property (
    $rose(config_ready) |-> output_edge_select == (gate && edge_strap_pin))
    else $error("edge default wrong");
  a_strap_sync: assert property (
    $rose(config_ready) |-> cfg[3:2] == {2{gate && sync_strap_pin}})
    else $error("sync default wrong");
  a_strap_check: assert property (
    $rose(config_ready) |-> !rate_select && error_check_mode == {gate && check_strap_pin, 1'b0})
    else $error("check or rate default wrong");
  a_write_lands: assert property (
    config_ready && reg_wr_en && reg_addr == 8'h07 && reg_wdata[1:0] != 2'h3 |=>
    cfg == $past(reg_wdata))
    else $error("write not stored");
  a_forbidden_kept: assert property (
    config_ready && reg_wr_en && reg_addr == 8'h07 && reg_wdata[1:0] == 2'h3 |=>
    ((cfg ^ $past(reg_wdata)) & 8'hFC) == 8'h00 && error_check_mode == $past(error_check_mode))
    else $error("forbidden code stored");
  a_parity_path: assert property (
    config_ready && link_valid && error_check_mode == 2'h0 |=> out_valid &&
    out_data == $past(link_data) &&
    err_detected == ^{$past(link_data), $past(link_check) & 6'h01})
    else $error("parity path wrong");
endmodule : lfcr_checker
bind lfcr_link_format lfcr_checker u_chk (.*);
`default_nettype wire

// ==== tb/lfcr_ser_model.sv ====
// Serializer model that sends checked words over the link side.
`timescale 1ns/1ps
`default_nettype none
module lfcr_ser_model
  import lfcr_pkg::*;
(
  input wire logic mclk,
  output logic link_valid,
  output logic [23:0] link_data,
  output logic [5:0] link_check
);
  // Lines start idle.
  initial begin
    link_valid = 1'b0;
    link_data = 24'h000000;
    link_check = 6'h00;
  end
  // One word for one cycle; afterwards the lines carry inverted junk, never stale data.
  task automatic send(input logic [23:0] d, input logic [5:0] c);
    @(posedge mclk);
    #1;
    {link_valid, link_data, link_check} = {1'b1, d, c};
    @(posedge mclk);
    #1;
    {link_valid, link_data, link_check} = {1'b0, ~d, ~c};
  endtask : send
endmodule : lfcr_ser_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Testbench for the link format register with a serializer model on the link side.
`timescale 1ns/1ps
`default_nettype none
module tb_top import lfcr_pkg::*;;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic local_channel_enable_pin, double_strap_pin, width_strap_pin;
  logic edge_strap_pin, sync_strap_pin, check_strap_pin, reg_rd_valid, config_ready;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic double_input_select, rate_select, word_width_select, output_edge_select;
  logic sync_tracking_enable, sync_encoding_enable, out_valid, err_detected, err_corrected;
  logic link_valid;
  logic [1:0] error_check_mode;
  logic [23:0] link_data, out_data;
  logic [5:0] link_check;
  int n_errors = 0;
  int n_compared = 0;
  logic [13:0] boots [4] = '{14'h1FBE, 14'h179E, 14'h0A2C, 14'h3F00};
  logic [15:0] wr_tab [4] = '{16'h5555, 16'hA6A6, 16'hFFFE, 16'h0000};
  lfcr_link_format dut (.*);
  lfcr_ser_model partner (.*);
  // 100 MHz clock.
  always #5 mclk = ~mclk;
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Applies a strap pattern, holds reset six cycles, then lets the defaults load.
  task automatic boot(input logic [5:0] p);
    {local_channel_enable_pin, double_strap_pin, width_strap_pin, edge_strap_pin,
      sync_strap_pin, check_strap_pin} = p;
    rst = 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge mclk);
  endtask : boot
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    {reg_wr_en, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge mclk);
    #1;
    reg_wr_en = 1'b0;
  endtask : wr
  // Read strobe for one cycle; the answer is looked at in the cycle after.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    #1;
    {reg_rd_en, reg_addr} = {1'b1, a};
    @(posedge mclk);
    #1;
    reg_rd_en = 1'b0;
    chk("rd_valid", 24'h1, {23'h0, reg_rd_valid});
    chk("rdata", {16'h0, e}, {16'h0, reg_rdata});
  endtask : rd
  task automatic end_sim;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  // Strap defaults, register writes, refusals, then the parity and Hamming paths.
  initial begin
    foreach (boots[i]) begin
      boot(boots[i][13:8]);
      rd(8'h07, boots[i][7:0]);
    end
    foreach (wr_tab[i]) begin
      wr(8'h07, wr_tab[i][15:8]);
      rd(8'h07, wr_tab[i][7:0]);
    end
    wr(8'h06, 8'h02);
    rd(8'h06, 8'h02);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    partner.send(24'h000001, 6'h00);
    chk("parity flags", 24'h3, {22'h0, out_valid, err_detected});
    partner.send(24'h000001, 6'h01);
    chk("parity flags", 24'h2, {22'h0, out_valid, err_detected});
    chk("out_data", 24'h000001, out_data);
    // Six-bit CRC of 000001 with polynomial 03, start value 0, most significant bit first, is 03.
    wr(8'h07, 8'h01);
    partner.send(24'h000001, 6'h03);
    chk("crc flags", 24'h2, {22'h0, out_valid, err_detected});
    partner.send(24'h000001, 6'h00);
    chk("crc flags", 24'h3, {22'h0, out_valid, err_detected});
    // Sixteen words fill the store; slot 1 holds the word with data bit 0 flipped.
    wr(8'h07, 8'h02);
    for (int i = 0; i < 16; i++) begin
      partner.send((i == 1) ? 24'h5A5A5B : 24'h5A5A5A, 6'h00);
      chk("fill", 24'h0, {23'h0, out_valid});
    end
    // Code 11 is clean for 5A5A5A; code 12 has two check bits flipped.
    partner.send(24'h5A5A5A, 6'h11);
    chk("ham clean", 24'h4, {21'h0, out_valid, err_corrected, err_detected});
    chk("ham data", 24'h5A5A5A, out_data);
    partner.send(24'h5A5A5A, 6'h11);
    chk("ham single", 24'h6, {21'h0, out_valid, err_corrected, err_detected});
    chk("ham data", 24'h5A5A5A, out_data);
    partner.send(24'h5A5A5A, 6'h12);
    chk("ham double", 24'h5, {21'h0, out_valid, err_corrected, err_detected});
    end_sim();
  end
  // Cuts a hang short well past the expected run length.
  initial begin
    #20000;
    n_errors++;
    end_sim();
  end
endmodule : tb_top
`default_nettype wire

// ==== verilog/lfcr_consts.svh ====
// Offsets, field positions, reset values and widths of the link format register.
`ifndef LFCR_CONSTS_SVH
`define LFCR_CONSTS_SVH

`define LFCR_ADDR_RESERVED 8'h06
`define LFCR_ADDR_CONFIG 8'h07
`define LFCR_RESERVED_VALUE 8'h02
`define LFCR_BIT_DOUBLE 7
`define LFCR_BIT_RATE 6
`define LFCR_BIT_WIDTH 5
`define LFCR_BIT_EDGE 4
`define LFCR_BIT_TRACK 3
`define LFCR_BIT_ENCODE 2
`define LFCR_CHECK_MSB 1
`define LFCR_CHECK_LSB 0
`define LFCR_CHECK_PARITY 2'h0
`define LFCR_CHECK_CRC 2'h1
`define LFCR_CHECK_HAMMING 2'h2
`define LFCR_CHECK_FORBIDDEN 2'h3
`define LFCR_CONFIG_RESET 8'h00
`define LFCR_DATA_WIDTH 24
`define LFCR_CODE_WIDTH 6
`define LFCR_INTERLEAVE_DEPTH 16
`define LFCR_SLOT_WIDTH 4
`define LFCR_CRC_POLY 6'h03
`define LFCR_READ_UNMAPPED 8'h00

`endif

// ==== verilog/lfcr_hamming_fix.sv ====
// Single-error-correct, double-error-detect decoder for one 24-bit word with a 6-bit code.
`timescale 1ns/1ps
`default_nettype none
`include "lfcr_consts.svh"

module lfcr_hamming_fix
  import lfcr_pkg::*;
(
  input wire logic [`LFCR_DATA_WIDTH-1:0] data_in,
  input wire logic [`LFCR_CODE_WIDTH-1:0] code_in,
  output logic [`LFCR_DATA_WIDTH-1:0] data_fixed,
  output logic single_err,
  output logic double_err
);

  // Data sits at the non-power-of-two positions 3..29, check bits at 1,2,4,8,16, bit 5 is overall.
  always_comb begin
    logic [29:0] word;
    logic [4:0] syndrome;
    logic overall;
    int d;
    int k;
    word = 30'h00000000;
    syndrome = 5'h00;
    overall = 1'b0;
    d = 0;
    k = 0;
    for (int p = 1; p < 30; p++) begin
      if ((p & (p - 1)) == 0) begin
        word[p] = code_in[k]; // Check bit k sits at position two to the power k.
        k = k + 1;
      end else begin
        word[p] = data_in[d];
        d = d + 1;
      end
      if (word[p]) begin
        syndrome = syndrome ^ 5'(p);
      end
    end
    overall = (^data_in) ^ (^code_in);
    single_err = overall;
    double_err = (syndrome != 5'h00) && !overall;
    if (overall && (syndrome != 5'h00) && (syndrome < 5'd30)) begin
      word[syndrome] = ~word[syndrome];
    end
    data_fixed = {`LFCR_DATA_WIDTH{1'b0}};
    d = 0;
    for (int p = 1; p < 30; p++) begin
      if ((p & (p - 1)) != 0) begin
        data_fixed[d] = word[p];
        d = d + 1;
      end
    end
  end

endmodule : lfcr_hamming_fix

`default_nettype wire

// ==== verilog/lfcr_link_format.sv ====
// Link format configuration register with strap defaults and the selected error check path.
`timescale 1ns/1ps
`default_nettype none
`include "lfcr_consts.svh"

// What this block does
// - Bit 7 picks single (0) or double (1) input, and starts at double only when the local enable pin is low and the double strap is high.
// - Bit 5 picks 24-bit (0) or 32-bit (1) words, and starts at 32-bit only when the local enable pin is low and the width strap is high.
// - Bit 4 picks the output clock edge, 0 meaning data valid on the rising edge, and starts at 1 only when the local enable pin is low and the edge strap is high.
// - Bit 3 turns sync tracking off (0) or on (1), and starts on only when the local enable pin is low and the sync strap is high.
// - Bit 2 turns sync encoding off (0) or on (1), and starts on only when the local enable pin is low and the sync strap is high.
// - Bits 1:0 pick parity (00), six-bit CRC (01) or six-bit Hamming correction (10), and 11 is never to be written.
// - In Hamming mode single-bit errors are corrected and double-bit errors detected, with codes interleaved across sixteen words.
// - The check field starts at Hamming when the local enable pin is low and the check strap is high, and at parity otherwise.
module lfcr_link_format
  import lfcr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic local_channel_enable_pin,
  input wire logic double_strap_pin,
  input wire logic width_strap_pin,
  input wire logic edge_strap_pin,
  input wire logic sync_strap_pin,
  input wire logic check_strap_pin,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  output logic config_ready,
  output logic double_input_select,
  output logic rate_select,
  output logic word_width_select,
  output logic output_edge_select,
  output logic sync_tracking_enable,
  output logic sync_encoding_enable,
  output logic [1:0] error_check_mode,
  input wire logic link_valid,
  input wire logic [`LFCR_DATA_WIDTH-1:0] link_data,
  input wire logic [`LFCR_CODE_WIDTH-1:0] link_check,
  output logic out_valid,
  output logic [`LFCR_DATA_WIDTH-1:0] out_data,
  output logic err_detected,
  output logic err_corrected
);

  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  lfcr_phase_e phase;
  lfcr_byte_t config_q;
  lfcr_byte_t next_config;
  lfcr_byte_t strap_config;
  logic [`LFCR_DATA_WIDTH-1:0] delay_mem [`LFCR_INTERLEAVE_DEPTH];
  logic [`LFCR_INTERLEAVE_DEPTH-1:0] slot_full;
  logic [`LFCR_SLOT_WIDTH-1:0] slot;
  logic [`LFCR_DATA_WIDTH-1:0] ham_fixed;
  logic ham_single;
  logic ham_double;
  logic [`LFCR_CODE_WIDTH-1:0] crc_value;

  // Strap and enable pins come from outside and pass two flip-flops first.
  always_ff @(posedge mclk) begin
    pin_meta <= {local_channel_enable_pin, double_strap_pin, width_strap_pin,
                 edge_strap_pin, sync_strap_pin, check_strap_pin};
    pin_sync <= pin_meta;
  end

  // Power-up value of each field but the rate bit from the synchronised straps; the rate bit always starts at 0.
  always_comb begin
    strap_config = `LFCR_CONFIG_RESET;
    if (!pin_sync[5]) begin
      strap_config[`LFCR_BIT_DOUBLE] = pin_sync[4];
      strap_config[`LFCR_BIT_WIDTH] = pin_sync[3];
      strap_config[`LFCR_BIT_EDGE] = pin_sync[2];
      strap_config[`LFCR_BIT_TRACK] = pin_sync[1];
      strap_config[`LFCR_BIT_ENCODE] = pin_sync[1];
      if (pin_sync[0]) begin
        strap_config[`LFCR_CHECK_MSB:`LFCR_CHECK_LSB] = `LFCR_CHECK_HAMMING;
      end
    end
    strap_config[`LFCR_BIT_RATE] = 1'b0;
  end

  // Start-up sequence: wait one cycle for the synchronisers to fill, then load the straps.
  always_ff @(posedge mclk) begin
    if (rst) begin
      phase <= LFCR_PH_HOLD;
    end else begin
      unique case (phase)
        LFCR_PH_HOLD: begin
          phase <= LFCR_PH_SETTLE;
        end
        LFCR_PH_SETTLE: begin
          phase <= LFCR_PH_RUN;
        end
        LFCR_PH_RUN: begin
          phase <= LFCR_PH_RUN;
        end
        default: begin
          phase <= LFCR_PH_HOLD;
        end
      endcase
    end
  end

  // Host write: a forbidden check code leaves the old check setting in place.
  always_comb begin
    next_config = config_q;
    if (phase == LFCR_PH_SETTLE) begin
      next_config = strap_config;
    end else if (phase == LFCR_PH_RUN && reg_wr_en && reg_addr == `LFCR_ADDR_CONFIG) begin
      next_config = reg_wdata;
      if (reg_wdata[`LFCR_CHECK_MSB:`LFCR_CHECK_LSB] == `LFCR_CHECK_FORBIDDEN) begin
        next_config[`LFCR_CHECK_MSB:`LFCR_CHECK_LSB] =
          config_q[`LFCR_CHECK_MSB:`LFCR_CHECK_LSB];
      end
    end
  end

  // Configuration register; the edge bit is applied as written, the host times its change.
  always_ff @(posedge mclk) begin
    if (rst) begin
      config_q <= `LFCR_CONFIG_RESET;
    end else begin
      config_q <= next_config;
    end
  end

  // Field outputs follow the register directly.
  always_comb begin
    double_input_select = config_q[`LFCR_BIT_DOUBLE];
    rate_select = config_q[`LFCR_BIT_RATE];
    word_width_select = config_q[`LFCR_BIT_WIDTH];
    output_edge_select = config_q[`LFCR_BIT_EDGE];
    sync_tracking_enable = config_q[`LFCR_BIT_TRACK];
    sync_encoding_enable = config_q[`LFCR_BIT_ENCODE];
    error_check_mode = config_q[`LFCR_CHECK_MSB:`LFCR_CHECK_LSB];
    config_ready = phase[2]; // One-hot bit of the running phase, straight from its flop.
  end

  // Register read; the reserved location always shows its fixed pattern and ignores writes.
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        if (reg_addr == `LFCR_ADDR_CONFIG) begin
          reg_rdata <= config_q;
        end else if (reg_addr == `LFCR_ADDR_RESERVED) begin
          reg_rdata <= `LFCR_RESERVED_VALUE;
        end else begin
          reg_rdata <= `LFCR_READ_UNMAPPED;
        end
      end
    end
  end

  // Six-bit CRC over the data word, most significant bit first.
  always_comb begin
    logic fb;
    fb = 1'b0;
    crc_value = 6'h00;
    for (int i = `LFCR_DATA_WIDTH - 1; i >= 0; i--) begin
      fb = crc_value[5] ^ link_data[i];
      crc_value = {crc_value[4:0], 1'b0};
      if (fb) begin
        crc_value = crc_value ^ `LFCR_CRC_POLY;
      end
    end
  end

  // The code arriving now belongs to the word received sixteen words earlier in this slot.
  lfcr_hamming_fix u_hamming_fix (
    .data_in(delay_mem[slot]),
    .code_in(link_check),
    .data_fixed(ham_fixed),
    .single_err(ham_single),
    .double_err(ham_double)
  );

  // Interleave store: one word per slot, slot index wraps over sixteen words.
  always_ff @(posedge mclk) begin
    if (rst) begin
      slot <= 4'h0;
      slot_full <= 16'h0000;
    end else if (!config_ready ||
                 error_check_mode != `LFCR_CHECK_HAMMING) begin
      slot <= 4'h0;
      slot_full <= 16'h0000;
    end else if (link_valid) begin
      delay_mem[slot] <= link_data;
      slot_full[slot] <= 1'b1;
      slot <= slot + 4'h1;
    end
  end

  // Checked output word and error pulses for the selected check mode.
  always_ff @(posedge mclk) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data <= {`LFCR_DATA_WIDTH{1'b0}};
      err_detected <= 1'b0;
      err_corrected <= 1'b0;
    end else begin
      out_valid <= 1'b0;
      err_detected <= 1'b0;
      err_corrected <= 1'b0;
      if (link_valid && config_ready) begin
        unique case (error_check_mode)
          `LFCR_CHECK_PARITY: begin
            out_valid <= 1'b1;
            out_data <= link_data;
            err_detected <= (^link_data) ^ link_check[0];
          end
          `LFCR_CHECK_CRC: begin
            out_valid <= 1'b1;
            out_data <= link_data;
            err_detected <= (crc_value != link_check);
          end
          `LFCR_CHECK_HAMMING: begin
            out_valid <= slot_full[slot];
            out_data <= ham_fixed;
            err_detected <= slot_full[slot] && ham_double;
            err_corrected <= slot_full[slot] && ham_single;
          end
          `LFCR_CHECK_FORBIDDEN: begin
            out_valid <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule : lfcr_link_format

`default_nettype wire

// ==== verilog/lfcr_pkg.sv ====
// Types shared by the link format register block.
package lfcr_pkg;

  typedef logic [7:0] lfcr_byte_t;

  // Start-up phases: reset held, strap settling, normal running.
  typedef enum logic [2:0] {
    LFCR_PH_HOLD = 3'b001,
    LFCR_PH_SETTLE = 3'b010,
    LFCR_PH_RUN = 3'b100
  } lfcr_phase_e;

endpackage : lfcr_pkg
